// ### rtl/spi_core_pkg.sv
// shared constants for the byte serial port core
package spi_core_pkg;

   // control register field positions
   localparam int CR_IRQ_ENABLE_POS = 7;
   localparam int CR_PORT_ENABLE_POS = 6;
   localparam int CR_RATE2_POS = 5;
   localparam int CR_CONTROLLER_POS = 4;
   localparam int CR_IDLE_LEVEL_POS = 3;
   localparam int CR_CAPTURE_PHASE_POS = 2;
   localparam int CR_RATE1_POS = 1;
   localparam int CR_RATE0_POS = 0;

   // control/status register field positions
   localparam int CSR_DONE_POS = 7;
   localparam int CSR_COLLISION_POS = 6;
   localparam int CSR_OVERRUN_POS = 5;
   localparam int CSR_FAULT_POS = 4;
   localparam int CSR_OUTPUT_DISABLE_POS = 2;
   localparam int CSR_SOFT_MANAGE_POS = 1;
   localparam int CSR_SOFT_LEVEL_POS = 0;

   // reset values
   localparam logic [7:0] CR_RESET = 8'h00;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // rate codes {rate2, rate1, rate0}
   localparam logic [2:0] RATE_DIV4 = 3'h4;
   localparam logic [2:0] RATE_DIV8 = 3'h0;
   localparam logic [2:0] RATE_DIV16 = 3'h1;
   localparam logic [2:0] RATE_DIV32 = 3'h6;
   localparam logic [2:0] RATE_DIV64 = 3'h2;
   localparam logic [2:0] RATE_DIV128 = 3'h3;

   // half periods of the serial clock in cpu clocks
   localparam int HALF_PERIOD_WIDTH = 7;
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV8 = 7'h04;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV32 = 7'h10;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;

   // transfer framing
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [4:0] LAST_HALF = 5'h0F;
   localparam int RX_FIFO_DEPTH = 4;

   // controller sequencer states
   typedef enum logic [2:0] {
      CTL_IDLE = 3'b001,
      CTL_WAIT_ROOM = 3'b010,
      CTL_SHIFT = 3'b100
   } ctl_state_type;

endpackage

// ### rtl/sck_rate_divider.sv
// one-cycle tick every half period of the controller serial clock
`timescale 1ns/100ps
`default_nettype none
module sck_rate_divider
   import spi_core_pkg::*;
#(
   parameter int WIDTH = HALF_PERIOD_WIDTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic run,
   input wire logic [WIDTH-1:0] half_period,
   // output
   output logic tick
);

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("sck_rate_divider: WIDTH must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   wire at_end = (count == (half_period - WIDTH'(1)));

   // restart from zero whenever stopped so the first half period is full length
   assign next_count = (!run || at_end) ? '0 : count + WIDTH'(1);
   assign tick = run && at_end;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule // sck_rate_divider
`default_nettype wire

// ### rtl/byte_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("byte_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] level;

   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (level < (PTR_W+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + PTR_W'(1);
         end
         if (push && !pop) begin
            level <= level + (PTR_W+1)'(1);
         end else if (pop && !push) begin
            level <= level - (PTR_W+1)'(1);
         end
      end
   end

endmodule // byte_fifo
`default_nettype wire

// ### rtl/spi_master_slave_core.sv
// byte serial port core, controller or target role, with flags and low-power handling
// Notes on behaviour
// - controller role needs internal select high all byte, else role and enable drop
// - controller data write loads shift register, drives clock, sends msb first
// - byte end sets done flag; interrupt when enabled and processor mask clear
// - done flag clears by status access while set, then data read or write
// - data writes ignored while done flag set until status has been read
// - target role: match clock settings, clear role bit, set port enable
// - target takes outside clock, sends loaded byte msb first on target output
// - idle level and capture phase choose capture edge, same in both roles
// - select low in controller role: fault flag, drop enable and role bits
// - fault flag clears by status read while set, then control write
// - while faulted, setting enable and role refused outside clearing sequence
// - byte end with done set: overrun flag, buffer keeps first byte
// - data write during transfer discarded, collision flag set, no interrupt
// - received byte copied to buffer; data reads never disturb shifting
// - wait keeps running and wakes; halt drops software access and stops the controller; a target selected at entry keeps shifting
// - halt wake only from done flag in target role with select low at entry
// - done, fault and overrun events share one interrupt line, each gated by enable and mask
// - idle level zero idles clock low, one idles it high
// - phase zero captures on first transition, phase one on second
// - controller rate bits give divide by 4 to 128, ignored in target role
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_core
   import spi_core_pkg::*;
#(
   parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // software access strobes
   input wire logic cr_write,
   input wire logic [7:0] cr_wdata,
   input wire logic csr_write,
   input wire logic [7:0] csr_wdata,
   input wire logic csr_read,
   input wire logic dr_write,
   input wire logic [7:0] dr_wdata,
   input wire logic dr_read,
   // software read data
   output logic [7:0] cr_rdata,
   output logic [7:0] csr_rdata,
   output logic [7:0] dr_rdata,
   // processor state
   input wire logic cpu_irq_mask,
   input wire logic wait_mode,
   input wire logic halt_mode,
   output logic irq,
   output logic wake_request,
   // serial pins
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in,
   // received byte stream
   output logic [7:0] rx_stream_data,
   output logic rx_stream_valid,
   input wire logic rx_stream_ready
);

   // control register bits
   logic irq_enable_bit;
   logic port_enable_bit;
   logic controller_role_bit;
   logic clock_idle_level;
   logic clock_capture_phase;
   logic [2:0] rate_divider_select;
   // control/status register bits
   logic output_disable_bit;
   logic select_soft_manage;
   logic select_soft_level;
   logic transfer_done_flag;
   logic write_collision_flag;
   logic overrun_flag;
   logic mode_fault_flag;
   // clearing sequence state
   logic done_armed;
   logic done_status_read;
   logic collision_armed;
   logic fault_armed;
   // shift engine
   ctl_state_type state;
   ctl_state_type next_state;
   logic [7:0] shifter;
   logic [7:0] rx_buffer;
   logic out_bit;
   logic cap_bit;
   logic [3:0] bit_count;
   logic [4:0] half_count;
   logic sck_reg;
   logic sck_prev;
   // low power
   logic halt_prev;
   logic halt_select_low;

   // registers are frozen against software in halt, so software strobes are dropped there
   wire cr_wr = cr_write && !halt_mode;
   wire csr_wr = csr_write && !halt_mode;
   wire csr_rd = csr_read && !halt_mode;
   wire dr_wr = dr_write && !halt_mode;
   wire dr_rd = dr_read && !halt_mode;
   wire csr_access = csr_wr || csr_rd;
   wire dr_access = dr_wr || dr_rd;

   wire select_n = select_soft_manage ? select_soft_level : ss_n_in;
   wire select_low = !select_n;
   wire controller_mode = port_enable_bit && controller_role_bit;
   wire target_enabled = port_enable_bit && !controller_role_bit;
   wire target_mode = target_enabled && select_low && (!halt_mode || halt_select_low);

   // selected half period of the generated clock
   wire [6:0] half_period = (rate_divider_select == RATE_DIV4) ? HALF_DIV4 :
                            (rate_divider_select == RATE_DIV8) ? HALF_DIV8 :
                            (rate_divider_select == RATE_DIV16) ? HALF_DIV16 :
                            (rate_divider_select == RATE_DIV32) ? HALF_DIV32 :
                            (rate_divider_select == RATE_DIV64) ? HALF_DIV64 :
                            HALF_DIV128;

   wire ctl_tick;
   wire ctl_run = (state == CTL_SHIFT) && !halt_mode;
   wire fifo_in_ready;

   sck_rate_divider #(
      .WIDTH(HALF_PERIOD_WIDTH)
   ) u_divider (
      .clk(clk),
      .resetn(resetn),
      .run(ctl_run),
      .half_period(half_period),
      .tick(ctl_tick)
   );

   // edge classification; leading edge leaves the idle level
   wire ctl_lead = ctl_tick && (sck_reg == clock_idle_level);
   wire ctl_trail = ctl_tick && (sck_reg != clock_idle_level);
   wire tgt_change = (sck_in != sck_prev);
   wire tgt_lead = target_mode && tgt_change && (sck_prev == clock_idle_level);
   wire tgt_trail = target_mode && tgt_change && (sck_prev != clock_idle_level);
   wire lead_edge = controller_role_bit ? ctl_lead : tgt_lead;
   wire trail_edge = controller_role_bit ? ctl_trail : tgt_trail;
   wire cap_edge = clock_capture_phase ? trail_edge : lead_edge;
   wire shift_edge = clock_capture_phase ? lead_edge : trail_edge;
   wire din = controller_role_bit ? miso_in : mosi_in;
   wire byte_done = cap_edge && (bit_count == LAST_BIT);
   wire [7:0] received = {shifter[6:0], din};

   // with phase clear the shift register is writable only while deselected
   wire tgt_busy = target_enabled && ((bit_count != 4'h0) ||
                                      (!clock_capture_phase && select_low));
   wire busy = (state != CTL_IDLE) || tgt_busy;
   wire dr_write_allowed = dr_wr && (!transfer_done_flag || done_status_read);
   wire collision = dr_write_allowed && busy;
   wire load = dr_write_allowed && !busy;

   // fault: own select pulled low while the role bit is set
   wire fault_set = controller_role_bit && select_low;
   wire fault_locked = mode_fault_flag && !fault_armed;

   wire done_clear = dr_access && done_armed;
   wire collision_clear = dr_access && collision_armed;
   wire fault_clear = cr_wr && fault_armed;

   // controller sequencer
   always_comb begin
      next_state = state;
      case (state)
         CTL_IDLE: begin
            if (load && controller_mode) begin
               next_state = CTL_WAIT_ROOM;
            end
         end
         CTL_WAIT_ROOM: begin
            // hold the start until the receive stream can take the byte
            if (fifo_in_ready) begin
               next_state = CTL_SHIFT;
            end
         end
         CTL_SHIFT: begin
            if (ctl_tick && half_count == LAST_HALF) begin
               next_state = CTL_IDLE;
            end
         end
         default: begin
            next_state = CTL_IDLE;
         end
      endcase
      if (fault_set || !controller_mode) begin
         next_state = CTL_IDLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= CTL_IDLE;
         half_count <= 5'h00;
         sck_reg <= 1'b0;
      end else begin
         state <= next_state;
         if (state != CTL_SHIFT) begin
            half_count <= 5'h00;
            sck_reg <= clock_idle_level;
         end else if (ctl_tick) begin
            half_count <= half_count + 5'h01;
            sck_reg <= !sck_reg;
         end
      end
   end

   // shift engine shared by both roles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shifter <= DATA_RESET;
         out_bit <= 1'b0;
         cap_bit <= 1'b0;
         bit_count <= 4'h0;
         sck_prev <= 1'b0;
      end else begin
         sck_prev <= sck_in;
         if (load) begin
            shifter <= dr_wdata;
            out_bit <= dr_wdata[7];
            bit_count <= 4'h0;
         end else if (byte_done) begin
            // the received byte goes back out unless software reloads; the last
            // bit holds through this capture edge, the echo msb follows on a shift edge
            shifter <= received;
            bit_count <= 4'h0;
         end else if (target_enabled && select_n && !halt_mode) begin
            bit_count <= 4'h0;
         end else begin
            if (cap_edge) begin
               cap_bit <= din;
               bit_count <= bit_count + 4'h1;
            end
            if (shift_edge && bit_count != 4'h0) begin
               shifter <= {shifter[6:0], cap_bit};
               out_bit <= shifter[6];
            end else if (shift_edge) begin
               // first shift edge of a byte presents the msb
               out_bit <= shifter[7];
            end
         end
      end
   end

   // control register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_enable_bit <= CR_RESET[CR_IRQ_ENABLE_POS];
         port_enable_bit <= CR_RESET[CR_PORT_ENABLE_POS];
         controller_role_bit <= CR_RESET[CR_CONTROLLER_POS];
         clock_idle_level <= CR_RESET[CR_IDLE_LEVEL_POS];
         clock_capture_phase <= CR_RESET[CR_CAPTURE_PHASE_POS];
         rate_divider_select <= {CR_RESET[CR_RATE2_POS], CR_RESET[CR_RATE1_POS],
                                 CR_RESET[CR_RATE0_POS]};
      end else begin
         if (cr_wr) begin
            irq_enable_bit <= cr_wdata[CR_IRQ_ENABLE_POS];
            port_enable_bit <= cr_wdata[CR_PORT_ENABLE_POS] && !fault_locked;
            controller_role_bit <= cr_wdata[CR_CONTROLLER_POS] && !fault_locked;
            clock_idle_level <= cr_wdata[CR_IDLE_LEVEL_POS];
            clock_capture_phase <= cr_wdata[CR_CAPTURE_PHASE_POS];
            rate_divider_select <= {cr_wdata[CR_RATE2_POS], cr_wdata[CR_RATE1_POS],
                                    cr_wdata[CR_RATE0_POS]};
         end
         // the fault wins over a same-cycle write so the outputs stay blocked
         if (fault_set) begin
            port_enable_bit <= 1'b0;
            controller_role_bit <= 1'b0;
         end
      end
   end

   // control/status register, software fields
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         output_disable_bit <= CSR_RESET[CSR_OUTPUT_DISABLE_POS];
         select_soft_manage <= CSR_RESET[CSR_SOFT_MANAGE_POS];
         select_soft_level <= CSR_RESET[CSR_SOFT_LEVEL_POS];
      end else if (csr_wr) begin
         output_disable_bit <= csr_wdata[CSR_OUTPUT_DISABLE_POS];
         select_soft_manage <= csr_wdata[CSR_SOFT_MANAGE_POS];
         select_soft_level <= csr_wdata[CSR_SOFT_LEVEL_POS];
      end
   end

   // status flags; a hardware set always beats a same-cycle clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         transfer_done_flag <= CSR_RESET[CSR_DONE_POS];
         write_collision_flag <= CSR_RESET[CSR_COLLISION_POS];
         overrun_flag <= CSR_RESET[CSR_OVERRUN_POS];
         mode_fault_flag <= CSR_RESET[CSR_FAULT_POS];
         done_armed <= 1'b0;
         done_status_read <= 1'b0;
         collision_armed <= 1'b0;
         fault_armed <= 1'b0;
         rx_buffer <= DATA_RESET;
      end else begin
         if (byte_done) begin
            transfer_done_flag <= 1'b1;
         end else if (done_clear) begin
            transfer_done_flag <= 1'b0;
         end
         if (byte_done && !transfer_done_flag) begin
            rx_buffer <= received;
         end
         if (byte_done && transfer_done_flag) begin
            overrun_flag <= 1'b1;
         end else if (csr_rd) begin
            overrun_flag <= 1'b0;
         end
         if (done_clear || byte_done) begin
            done_armed <= 1'b0;
            done_status_read <= 1'b0;
         end else if (transfer_done_flag) begin
            done_armed <= done_armed || csr_access;
            done_status_read <= done_status_read || csr_rd;
         end
         if (collision) begin
            write_collision_flag <= 1'b1;
            collision_armed <= 1'b0;
         end else if (collision_clear) begin
            write_collision_flag <= 1'b0;
            collision_armed <= 1'b0;
         end else if (csr_rd && write_collision_flag) begin
            collision_armed <= 1'b1;
         end
         if (fault_set) begin
            mode_fault_flag <= 1'b1;
            fault_armed <= 1'b0;
         end else if (fault_clear) begin
            mode_fault_flag <= 1'b0;
            fault_armed <= 1'b0;
         end else if (csr_rd && mode_fault_flag) begin
            fault_armed <= 1'b1;
         end
      end
   end

   // select level is caught as halt is entered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         halt_prev <= 1'b0;
         halt_select_low <= 1'b0;
      end else begin
         halt_prev <= halt_mode;
         if (halt_mode && !halt_prev) begin
            halt_select_low <= select_low;
         end
      end
   end

   // receive stream; a full buffer stalls the controller start, a target cannot stall
   byte_fifo #(
      .WIDTH(BYTE_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(byte_done),
      .in_data(received),
      .in_ready(fifo_in_ready),
      .out_valid(rx_stream_valid),
      .out_data(rx_stream_data),
      .out_ready(rx_stream_ready)
   );

   // interrupt and wake; collisions never interrupt
   wire any_event = transfer_done_flag || mode_fault_flag || overrun_flag;
   wire halt_wake = transfer_done_flag && halt_select_low && !controller_role_bit;
   assign irq = irq_enable_bit && any_event && !cpu_irq_mask;
   assign wake_request = irq_enable_bit && (halt_mode ? halt_wake :
                                            (wait_mode && any_event));

   // read data
   assign cr_rdata = {irq_enable_bit, port_enable_bit, rate_divider_select[2],
                      controller_role_bit, clock_idle_level, clock_capture_phase,
                      rate_divider_select[1:0]};
   assign csr_rdata = {transfer_done_flag, write_collision_flag, overrun_flag,
                       mode_fault_flag, 1'b0, output_disable_bit, select_soft_manage,
                       select_soft_level};
   assign dr_rdata = rx_buffer;

   // pins
   assign sck_out = sck_reg;
   assign sck_oe = controller_mode;
   assign mosi_out = out_bit;
   assign mosi_oe = controller_mode && !output_disable_bit;
   assign miso_out = out_bit;
   assign miso_oe = target_enabled && select_low && !output_disable_bit;

endmodule // spi_master_slave_core
`default_nettype wire

// ### dv/spi_master_slave_core_sva.sv
// port-level assertions for the byte serial port core
`timescale 1ns/100ps
`default_nettype none
module spi_core_checker
   import spi_core_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic resetn,
   input wire logic csr_read,
   input wire logic dr_read,
   input wire logic halt_mode,
   input wire logic cpu_irq_mask,
   input wire logic ss_n_in,
   input wire logic [7:0] cr_rdata,
   input wire logic [7:0] csr_rdata,
   input wire logic irq,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic miso_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire logic sel_n = csr_rdata[1] ? csr_rdata[0] : ss_n_in;
   sequence s_done_armed;
      csr_read && csr_rdata[7] && !halt_mode ##[1:4] dr_read && !halt_mode;
   endsequence
   a_done_clear: assert property (s_done_armed |=> !csr_rdata[7])
      else $error("done flag survived its clear sequence");
   a_fault_drops_role: assert property (cr_rdata[4] && !sel_n && !halt_mode
      |=> csr_rdata[4] && !cr_rdata[4] && !cr_rdata[6]) else $error("fault not taken");
   a_irq_gate: assert property (irq == (cr_rdata[7] && !cpu_irq_mask
      && (csr_rdata[7] || csr_rdata[5] || csr_rdata[4]))) else $error("irq gating wrong");
   a_sck_enable: assert property (sck_oe == (cr_rdata[6] && cr_rdata[4]))
      else $error("clock pin enable wrong");
   a_miso_enable: assert property (miso_oe == (cr_rdata[6] && !cr_rdata[4]
      && !sel_n && !csr_rdata[2])) else $error("target output enable wrong");
   a_coll_quiet: assert property ($rose(csr_rdata[6]) |-> $stable(irq))
      else $error("collision moved irq");
   a_rate_div4: assert property ($changed(sck_out)
      && {cr_rdata[5], cr_rdata[1:0]} == RATE_DIV4 |=> $stable(sck_out))
      else $error("clock half period too short");
   a_halt_frozen: assert property (halt_mode && $past(halt_mode) |-> $stable(cr_rdata))
      else $error("control register moved in halt");
endmodule // spi_core_checker
`default_nettype wire

// ### dv/spi_far_target.sv
// far-end target device answering the core's clock, idle low, capture on first edge
`timescale 1ns/100ps
`default_nettype none
module spi_far_target (
   // serial side
   input wire logic sck,
   input wire logic mosi,
   input wire logic active,
   output logic miso,
   // bench side
   input wire logic load,
   input wire logic [7:0] reply,
   output logic [7:0] got
);
   logic [7:0] tx = 8'h00;
   always @(posedge sck) got <= {got[6:0], mosi};
   always @(negedge sck or posedge load) begin
      if (load) tx <= reply;
      else tx <= {tx[6:0], ~tx[0]};
   end
   // released line shows the inverse so a stale bit never passes for data
   assign miso = active ? tx[7] : ~tx[7];
endmodule // spi_far_target
`default_nettype wire

// ### dv/spi_master_slave_core_tb.sv
// bench for the serial port core in controller and target roles, flags and halt
`timescale 1ns/100ps
`default_nettype none
module spi_master_slave_core_tb
   import spi_core_pkg::*;
;
   localparam int CR_W = 0, CSR_W = 1, CSR_R = 2, DR_W = 3, DR_R = 4;
   logic clk = 0, resetn = 0, cr_write = 0, csr_write = 0, csr_read = 0, dr_write = 0;
   logic dr_read = 0, cpu_irq_mask = 0, halt_mode = 0, ss_n_in = 1, far_load = 0;
   logic [7:0] cr_wdata = 8'h00, csr_wdata = 8'h00, dr_wdata = 8'h00, reply = 8'h3C;
   logic wait_mode = 0, sck_in = 0, mosi_in = 0, rx_stream_ready = 0;
   logic [7:0] tgt_seen = 8'h00;
   localparam logic [7:0] TGT_TX = 8'h5A;
   logic [7:0] cr_rdata, csr_rdata, dr_rdata, rx_stream_data, got;
   logic irq, wake_request, sck_out, sck_oe, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
   logic rx_stream_valid;
   int fails = 0, total_checks = 0;
   spi_master_slave_core u_dut (.*);
   spi_far_target u_far (.sck(sck_out), .mosi(mosi_out), .active(sck_oe), .miso(miso_in),
      .load(far_load), .reply(reply), .got(got));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic acc(input int k, input logic [7:0] d);
      @(posedge clk);
      case (k)
         CR_W: begin
            cr_write <= 1'b1;
            cr_wdata <= d;
         end
         CSR_W: begin
            csr_write <= 1'b1;
            csr_wdata <= d;
         end
         CSR_R: csr_read <= 1'b1;
         DR_W: begin
            dr_write <= 1'b1;
            dr_wdata <= d;
         end
         default: dr_read <= 1'b1;
      endcase
      @(posedge clk);
      {cr_write, csr_write, csr_read, dr_write, dr_read} <= 5'h00;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      far_load <= 1'b1;
      @(negedge clk);
      check("cr_reset", cr_rdata, CR_RESET);
      check("sck_reset", sck_out, 8'h00);
      @(posedge clk);
      far_load <= 1'b0;
      acc(CSR_W, 8'h03);
      acc(CR_W, 8'hF0);
      acc(DR_W, 8'hA5);
      repeat (4) @(posedge clk);
      acc(DR_W, 8'h11);
      for (int n = 0; n < 200 && csr_rdata[7] !== 1'b1; n++) @(negedge clk);
      check("sent", got, 8'hA5);
      check("rx_buffer", dr_rdata, 8'h3C);
      check("status", csr_rdata, 8'hC3);
      check("irq_done", irq, 8'h01);
      check("mosi_oe", mosi_oe, 8'h01);
      check("stream_data", rx_stream_data, 8'h3C);
      check("stream_valid", rx_stream_valid, 8'h01);
      acc(DR_W, 8'h22);
      repeat (40) @(negedge clk);
      check("refused", got, 8'hA5);
      check("sck_idle", sck_out, 8'h00);
      acc(CSR_R, 8'h00);
      acc(DR_R, 8'h00);
      @(negedge clk);
      check("cleared", csr_rdata, 8'h03);
      @(posedge clk);
      halt_mode <= 1'b1;
      acc(CR_W, 8'h00);
      @(negedge clk);
      check("halt_cr", cr_rdata, 8'hF0);
      check("halt_wake", wake_request, 8'h00);
      @(posedge clk);
      halt_mode <= 1'b0;
      cpu_irq_mask <= 1'b1;
      acc(CSR_W, 8'h00);
      ss_n_in <= 1'b0;
      repeat (2) @(negedge clk);
      check("fault", csr_rdata, 8'h10);
      check("fault_cr", cr_rdata, 8'hA0);
      check("masked", irq, 8'h00);
      @(posedge clk);
      cpu_irq_mask <= 1'b0;
      ss_n_in <= 1'b1;
      wait_mode <= 1'b1;
      @(negedge clk);
      check("fault_irq", irq, 8'h01);
      check("wait_wake", wake_request, 8'h01);
      acc(CR_W, 8'hF0);
      @(negedge clk);
      check("fault_refuse", cr_rdata, 8'hA0);
      acc(CSR_R, 8'h00);
      acc(CR_W, 8'hF0);
      @(negedge clk);
      check("fault_clear", {csr_rdata[4], cr_rdata[6:4]}, 8'h07);
      acc(CR_W, 8'h00);
      acc(CR_W, 8'hC0);
      acc(DR_W, 8'h96);
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         ss_n_in <= 1'b0;
         halt_mode <= !b;
         repeat (2) @(posedge clk);
         for (int k = 7; k >= 0; k--) begin
            sck_in <= 1'b1;
            mosi_in <= TGT_TX[k];
            @(posedge clk);
            sck_in <= 1'b0;
            tgt_seen <= {tgt_seen[6:0], miso_out};
            @(posedge clk);
         end
         ss_n_in <= 1'b1;
         @(negedge clk);
         check("tgt_out", tgt_seen, b ? 8'h5A : 8'h96);
         check("tgt_wake", wake_request, 8'h01);
      end
      check("tgt_rx", dr_rdata, TGT_TX);
      check("overrun", csr_rdata, 8'hA0);
      give_verdict;
   end
endmodule // spi_master_slave_core_tb
bind spi_master_slave_core spi_core_checker u_checker (.clk(clk), .resetn(resetn),
   .csr_read(csr_read), .dr_read(dr_read), .halt_mode(halt_mode),
   .cpu_irq_mask(cpu_irq_mask), .ss_n_in(ss_n_in), .cr_rdata(cr_rdata),
   .csr_rdata(csr_rdata), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .miso_oe(miso_oe));
`default_nettype wire
